/* verilog/mar_host.v */
`include "mar_consts.vh"
module mar_host #(
    parameter CHAN_W   = 3,
    parameter WAIT_MODE = 1
) (
    input  wire              CORE_CLK_IN,
    input  wire              SYS_RST_IN,
    input  wire              CLK_EN_IN,
    input  wire              REQ_IN,
    input  wire [CHAN_W-1:0] REQ_CHAN_IN,
    output reg               REQ_BUSY_OUT,
    output reg               DONE_OUT,
    output reg  [7:0]        DONE_DATA_OUT,
    output reg               TIMEOUT_OUT,
    output reg               CS_N_OUT,
    output reg               RD_N_OUT,
    output reg  [CHAN_W-1:0] CHAN_SEL_OUT,
    input  wire [7:0]        RESULT_BUS_IN,
    input  wire              RDY_IN,
    input  wire              DONE_N_IN
);
    // ----------------------------------------
    // timing
    // ----------------------------------------
    // ----------------------------------------
    // cycle counts, gap and conversion rounded up so spacing is never short; timeout truncated
    // ----------------------------------------
    localparam integer GAP_I   =
        (`MAR_GAP_NS * `MAR_CLK_MHZ + 999) / 1000;
    localparam integer CONV_I  =
        (`MAR_CONV_NS * `MAR_CLK_MHZ + 999) / 1000;
    localparam integer TO_I    =
        (`MAR_TIMEOUT_NS * `MAR_CLK_MHZ) / 1000;
    localparam integer SETUP_I = `MAR_SETUP_CYC;
    // counter is 16 bits; counts are cut to it on purpose
    localparam [15:0] GAP_CYC   = GAP_I[15:0];
    localparam [15:0] CONV_CYC  = CONV_I[15:0];
    localparam [15:0] TO_CYC    = TO_I[15:0];
    localparam [15:0] SETUP_CYC = SETUP_I[15:0];

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    wire [9:0] pins_s;
    mar_sync2 #(.W(10)) u_sync (
        .clk_in (CORE_CLK_IN),
        .ce_in  (CLK_EN_IN),
        .d_in   ({RDY_IN, DONE_N_IN, RESULT_BUS_IN}),
        .q_out  (pins_s)
    );
    wire       rdy_s    = pins_s[9];
    wire       done_n_s = pins_s[8];
    wire [7:0] data_s   = pins_s[7:0];

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    reg [2:0]  st_ff;
    reg [2:0]  nxt_st;
    reg [15:0] cnt_ff;
    reg [15:0] nxt_cnt;
    reg        seen_ff;
    reg        nxt_seen;

    // strobes low in these states only
    function strobe_on;
        input [2:0] st;
        begin
            strobe_on = (st == `MAR_ST_WAIT) || (st == `MAR_ST_HOLD);
        end
    endfunction

    // conversion finished, per mode
    function conv_done;
        input rdy;
        input dn;
        input seen;
        begin
            if (WAIT_MODE != 0)
                conv_done = seen & (rdy | ~dn);
            else
                conv_done = 1'b1;
        end
    endfunction

    always @* begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_seen = seen_ff;
        case (st_ff)
            `MAR_ST_IDLE: begin
                if (REQ_IN) begin
                    nxt_st  = `MAR_ST_SETUP;
                    nxt_cnt = SETUP_CYC;
                end
            end
            `MAR_ST_SETUP: begin
                // address settles before select falls
                if (cnt_ff <= 16'h0001) begin
                    nxt_st   = `MAR_ST_WAIT;
                    nxt_cnt  = 16'h0000;
                    nxt_seen = 1'b0;
                end else
                    nxt_cnt = cnt_ff - 16'h0001;
            end
            `MAR_ST_WAIT: begin
                nxt_cnt = cnt_ff + 16'h0001;
                // two sync stages hide the first ready fall
                if (cnt_ff >= `MAR_SYNC_LAT)
                    nxt_seen = 1'b1;
                if (WAIT_MODE == 0) begin
                    // no-wait: short strobe, previous byte
                    if (cnt_ff >= SETUP_CYC + `MAR_SYNC_LAT)
                        nxt_st = `MAR_ST_DONE;
                end else if (conv_done(rdy_s, done_n_s, seen_ff)) begin
                    nxt_st  = `MAR_ST_HOLD;
                    nxt_cnt = 16'h0000;
                end else if (cnt_ff >= TO_CYC)
                    nxt_st = `MAR_ST_DONE;
            end
            `MAR_ST_HOLD: begin
                // data valid when ready released
                nxt_st = `MAR_ST_DONE;
            end
            `MAR_ST_DONE: begin
                // strobe rise clears flag, latches address
                nxt_st  = `MAR_ST_GAP;
                nxt_cnt = 16'h0000;
            end
            `MAR_ST_GAP: begin
                nxt_cnt = cnt_ff + 16'h0001;
                // spacing covers conversion plus recovery
                if (cnt_ff >= GAP_CYC)
                    nxt_st = `MAR_ST_IDLE;
            end
            default: nxt_st = `MAR_ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers and pins
    // ----------------------------------------
    always @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            st_ff         <= `MAR_ST_IDLE;
            cnt_ff        <= 16'h0000;
            seen_ff       <= 1'b0;
            REQ_BUSY_OUT  <= 1'b0;
            DONE_OUT      <= 1'b0;
            DONE_DATA_OUT <= 8'h00;
            TIMEOUT_OUT   <= 1'b0;
            CS_N_OUT      <= 1'b1;
            RD_N_OUT      <= 1'b1;
            CHAN_SEL_OUT  <= {CHAN_W{1'b0}};
        end else if (CLK_EN_IN) begin
            st_ff        <= nxt_st;
            cnt_ff       <= nxt_cnt;
            seen_ff      <= nxt_seen;
            REQ_BUSY_OUT <= (nxt_st != `MAR_ST_IDLE);
            DONE_OUT     <= 1'b0;
            TIMEOUT_OUT  <= 1'b0;
            if (st_ff == `MAR_ST_IDLE && REQ_IN)
                CHAN_SEL_OUT <= REQ_CHAN_IN;
            // select and read low together start it
            CS_N_OUT <= ~strobe_on(nxt_st);
            RD_N_OUT <= ~strobe_on(nxt_st);
            if (st_ff == `MAR_ST_HOLD ||
                (WAIT_MODE == 0 && st_ff == `MAR_ST_WAIT &&
                 nxt_st == `MAR_ST_DONE)) begin
                DONE_OUT      <= 1'b1;
                DONE_DATA_OUT <= data_s;
            end
            if (WAIT_MODE != 0 && st_ff == `MAR_ST_WAIT &&
                nxt_st == `MAR_ST_DONE)
                TIMEOUT_OUT <= 1'b1; // grounded ready never releases
        end
    end
    // ready pin is open drain, sensed only
endmodule // mar_host

/* verilog/mar_consts.vh */
// Functional notes
// - wait-state mode only used by a host able to stretch its read.
// - host holds channel address steady while select and read are low.
// - unused ready may be grounded with no pull-up.
// - no-wait mode: ready carries no status and is grounded.
// - no-wait mode: flag asserts at end; host issues second read. Here: one read per request, flag ignored, previous byte returned.
// - no-wait mode: at least 2.5 us between successive reads.
// - converter acts as read-only memory via select, read, address.
// - host uses three low address bits 000 to 111 as channel.
// - wait mode: host may use flag fall as transfer acknowledge.
`ifndef MAR_CONSTS_VH
`define MAR_CONSTS_VH
`define MAR_CLK_MHZ        40
`define MAR_GAP_NS         2500
`define MAR_CONV_NS        2000
`define MAR_SETUP_CYC      2
`define MAR_TIMEOUT_NS     20000
`define MAR_SYNC_LAT       16'h0003
`define MAR_ST_IDLE        3'h0
`define MAR_ST_SETUP       3'h1
`define MAR_ST_WAIT        3'h2
`define MAR_ST_HOLD        3'h3
`define MAR_ST_DONE        3'h4
`define MAR_ST_GAP         3'h5
`endif

/* verilog/mar_sync2.v */
module mar_sync2 #(
    parameter W = 1
) (
    input  wire         clk_in,
    input  wire         ce_in,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;
    // pins come from the converter, not this clock
    always @(posedge clk_in) begin
        if (ce_in) begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end
    assign q_out = sync_ff;
endmodule // mar_sync2

/* test/mar_adc_model.sv */
module mar_adc_model #(
    parameter NOWAIT = 0
) (
    input  wire       cs_n_in,
    input  wire       rd_n_in,
    input  wire [2:0] chan_in,
    output wire [7:0] result_out,
    output wire       rdy_out,
    output logic      done_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       rdy_low = 1'b0;
    logic       drive   = 1'b0;
    logic [7:0] last    = 8'h00;
    logic       armed   = 1'b0;
    initial done_n_out = 1'b1;
    // released pin: pull-up wins; no-wait ties it to ground
    assign rdy_out = (NOWAIT != 0) ? 1'b0 : ~rdy_low;
    // undriven bus shows the inverse, never a stale byte
    assign result_out = drive ? last : ~last;
    always @(negedge cs_n_in or negedge rd_n_in) begin
        if (NOWAIT != 0 && !cs_n_in && !rd_n_in) begin
            drive = 1'b1;
            armed = 1'b1;
        end else if (!cs_n_in && !rd_n_in) begin
            rdy_low = 1'b1;
            #2000;
            if (!cs_n_in && !rd_n_in) begin
                last       = 8'hA0 + chan_in;
                drive      = 1'b1;
                rdy_low    = 1'b0;
                done_n_out = 1'b0;
            end
        end
    end
    // no-wait: address taken on read rise, conversion runs on its own
    always @(posedge rd_n_in) begin
        if (armed) begin
            armed = 1'b0;
            last       <= #2000 8'hA0 + chan_in;
            done_n_out <= #2000 1'b0;
        end
    end
    always @(posedge cs_n_in or posedge rd_n_in) begin
        drive      = 1'b0;
        done_n_out = 1'b1;
    end
endmodule // mar_adc_model

/* test/mar_host_chk.sv */
module mar_host_chk #(
    parameter CHAN_W = 3
) (
    input wire              CORE_CLK_IN,
    input wire              SYS_RST_IN,
    input wire              REQ_IN,
    input wire              REQ_BUSY_OUT,
    input wire              DONE_OUT,
    input wire              TIMEOUT_OUT,
    input wire              CS_N_OUT,
    input wire              RD_N_OUT,
    input wire [CHAN_W-1:0] CHAN_SEL_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    a_strobes_paired: assert property (CS_N_OUT == RD_N_OUT)
        else $error("strobes split");
    a_busy_on_req: assert property (REQ_IN && !REQ_BUSY_OUT |=> REQ_BUSY_OUT)
        else $error("request not taken");
    a_idle_quiet: assert property (!REQ_BUSY_OUT |-> CS_N_OUT)
        else $error("strobe while idle");
    a_addr_held: assert property (!CS_N_OUT |-> $stable(CHAN_SEL_OUT))
        else $error("address moved");
    a_gap_kept: assert property ($rose(CS_N_OUT) |=> CS_N_OUT[*8])
        else $error("strobe too soon");
    a_no_early: assert property ($fell(CS_N_OUT) |=> !DONE_OUT[*3])
        else $error("done too early");
    a_done_bound: assert property ($fell(CS_N_OUT) |-> ##[1:900] (DONE_OUT || TIMEOUT_OUT))
        else $error("no completion");
    a_strobe_rel: assert property (DONE_OUT |-> ##[0:2] CS_N_OUT)
        else $error("strobe not released");
endmodule // mar_host_chk

/* test/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk  = 1'b0;
    logic       rst  = 1'b1;
    logic       req  = 1'b0;
    logic [2:0] chan = 3'h0;
    wire        busy, done, tmo, cs_n, rd_n, rdy, dn_n;
    wire  [7:0] data, bus;
    wire  [2:0] sel;
    logic       nw_req  = 1'b0;
    logic [2:0] nw_chan = 3'h0;
    wire        nw_busy, nw_done, nw_cs_n, nw_rd_n, nw_rdy, nw_dn_n;
    wire  [7:0] nw_data, nw_bus;
    wire  [2:0] nw_sel;
    int         failures    = 0;
    int         checks_done = 0;
    initial forever #12.5 clk = ~clk;
    mar_host dut_u (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(1'b1),
        .REQ_IN(req), .REQ_CHAN_IN(chan), .REQ_BUSY_OUT(busy),
        .DONE_OUT(done), .DONE_DATA_OUT(data), .TIMEOUT_OUT(tmo),
        .CS_N_OUT(cs_n), .RD_N_OUT(rd_n), .CHAN_SEL_OUT(sel),
        .RESULT_BUS_IN(bus), .RDY_IN(rdy), .DONE_N_IN(dn_n));
    mar_adc_model adc_u (.cs_n_in(cs_n), .rd_n_in(rd_n), .chan_in(sel),
        .result_out(bus), .rdy_out(rdy), .done_n_out(dn_n));
    mar_host #(.WAIT_MODE(0)) dut_nw_u (.CORE_CLK_IN(clk),
        .SYS_RST_IN(rst), .CLK_EN_IN(1'b1), .REQ_IN(nw_req),
        .REQ_CHAN_IN(nw_chan), .REQ_BUSY_OUT(nw_busy),
        .DONE_OUT(nw_done), .DONE_DATA_OUT(nw_data), .TIMEOUT_OUT(),
        .CS_N_OUT(nw_cs_n), .RD_N_OUT(nw_rd_n), .CHAN_SEL_OUT(nw_sel),
        .RESULT_BUS_IN(nw_bus), .RDY_IN(nw_rdy), .DONE_N_IN(nw_dn_n));
    mar_adc_model #(.NOWAIT(1)) nwm_u (.cs_n_in(nw_cs_n),
        .rd_n_in(nw_rd_n), .chan_in(nw_sel), .result_out(nw_bus),
        .rdy_out(nw_rdy), .done_n_out(nw_dn_n));
    task check(input logic ok, input string msg);
        checks_done++;
        if (!ok) begin
            failures++;
            $display("unexpected %0t %s", $time, msg);
        end
    endtask
    task complete_run;
        if (failures == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task read_chan(input logic [2:0] c);
        int n;
        n = 0;
        while (busy !== 1'b0) @(posedge clk);
        @(posedge clk) #2 req = 1'b1;
        chan = c;
        @(posedge clk) #2 req = 1'b0;
        while (done !== 1'b1 && n < 1000) begin
            @(posedge clk) #2 n++;
        end
        check(done === 1'b1 && n > 80, "late or early");
        check(data === 8'hA0 + c, "wrong byte");
        check(tmo === 1'b0, "spurious timeout");
    endtask
    task nw_read(input logic [2:0] c, output logic [7:0] d);
        int n;
        n = 0;
        while (nw_busy !== 1'b0) @(posedge clk);
        @(posedge clk) #2 nw_req = 1'b1;
        nw_chan = c;
        @(posedge clk) #2 nw_req = 1'b0;
        while (nw_done !== 1'b1 && n < 1000) begin
            @(posedge clk) #2 n++;
        end
        check(nw_done === 1'b1, "no-wait read lost");
        d = nw_data;
    endtask
    // each no-wait read returns the conversion of the one before
    task nowait_chain;
        logic [7:0] d;
        nw_read(3'h3, d);
        nw_read(3'h6, d);
        check(d === 8'hA3, "not previous result");
        nw_read(3'h1, d);
        check(d === 8'hA6, "second read stale");
    endtask
    // abort mid-conversion, then recover
    task reset_mid;
        while (busy !== 1'b0) @(posedge clk);
        @(posedge clk) #2 req = 1'b1;
        @(posedge clk) #2 req = 1'b0;
        repeat (20) @(posedge clk);
        #2 rst = 1'b1;
        repeat (2) @(posedge clk);
        #2 check(cs_n === 1'b1 && busy === 1'b0, "reset ignored");
        rst = 1'b0;
        repeat (100) @(posedge clk);
        read_chan(3'h5);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #2 rst = 1'b0;
        for (int c = 0; c < 8; c++) read_chan(c[2:0]);
        nowait_chain();
        reset_mid();
        complete_run();
    end
    initial begin
        #200us;
        failures++;
        complete_run();
    end
endmodule // tb_top
bind mar_host mar_host_chk #(.CHAN_W(CHAN_W)) chk_u (.CORE_CLK_IN,
    .SYS_RST_IN, .REQ_IN, .REQ_BUSY_OUT, .DONE_OUT, .TIMEOUT_OUT,
    .CS_N_OUT, .RD_N_OUT, .CHAN_SEL_OUT);
